// file: shared/pdpai_pkg.sv
package pdpai_pkg;

	// Clock and derived timing
	localparam int unsigned CLK_PERIOD_PS      = 20000;
	localparam int unsigned START_DELAY_NS     = 80000;
	localparam int unsigned START_DELAY_CYCLES = (START_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned SW_PERIOD_NS       = 4670;
	localparam int unsigned SW_PERIOD_CYCLES   = SW_PERIOD_NS * 1000 / CLK_PERIOD_PS;
	localparam int unsigned FB_WINDOW_NS       = 1000;
	localparam int unsigned FB_WINDOW_CYCLES   = FB_WINDOW_NS * 1000 / CLK_PERIOD_PS;
	localparam int unsigned IND_PERIOD_NS      = 1280;
	localparam int unsigned IND_PERIOD_CYCLES  = IND_PERIOD_NS * 1000 / CLK_PERIOD_PS;

	// Gate delay programming, picoseconds and picoseconds per kilo-ohm
	localparam int unsigned FLY_PGD_SLOPE_PS   = 2690;
	localparam int unsigned FLY_PGD_OFS_PS     = 30000;
	localparam int unsigned FLY_SPACE_PS       = 20000;
	localparam int unsigned FWD_PGD_SLOPE_PS   = 7160;
	localparam int unsigned FWD_PGD_OFS_PS     = 17000;
	localparam int unsigned FWD_SPACE_SLOPE_PS = 5600;
	localparam int unsigned FWD_SPACE_OFS_PS   = 7900;

	// Classification events
	localparam logic [2:0] MAX_EVENTS = 3'h5;

	// Register map (byte addresses) and reset values
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_ONTIME = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_TIMING = 12'h00C;
	localparam logic        CTRL_RST   = 1'h1;
	localparam logic [7:0]  ONTIME_RST = 8'h40;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;

	typedef enum logic [4:0]
	{
		HS_OFF    = 5'h01,
		HS_CHARGE = 5'h02,
		HS_DELAY  = 5'h04,
		HS_RUN    = 5'h08,
		HS_AUX    = 5'h10
	} pdpai_hs_t;

	typedef enum logic [3:0]
	{
		IND_HIZ  = 4'h1,
		IND_LOWZ = 4'h2,
		IND_D50  = 4'h4,
		IND_D25  = 4'h8
	} pdpai_ind_t;

	// Least time in picoseconds to whole clock cycles, never below one
	function automatic logic [7:0] pdpai_cyc(input logic [19:0] ps);
		logic [19:0] q;
		q = (ps + 20'(CLK_PERIOD_PS - 1)) / 20'(CLK_PERIOD_PS);
		return (q == 20'h0) ? 8'h1 : q[7:0];
	endfunction

endpackage

// file: verilog/pdpai_switch.sv
`timescale 1ns/1ps
module pdpai_switch
	import pdpai_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       run,
	input  wire logic       forward,
	input  wire logic [5:0] kohm,
	input  wire logic [7:0] onTime,
	output logic            primaryGate,
	output logic            secondaryGate,
	output logic            feedbackEnable,
	output logic [7:0]      pgDelayCyc,
	output logic [7:0]      spacingCyc
);

	logic [7:0]  cycCnt_q;
	logic [19:0] pgdPs;
	logic [19:0] spacePs;
	logic [8:0]  pgOnAt;
	logic [8:0]  pgOffAt;
	logic [8:0]  sgOnAt;
	logic [8:0]  fbEndAt;
	logic [8:0]  cnt9;
	logic        pgOn;
	logic        sgOn;
	logic        fbOn;
	logic        wrap;

	// Resistor value programs the primary gate delay; forward scales the spacing too
	assign pgdPs   = forward ? 20'(FWD_PGD_SLOPE_PS) * 20'(kohm) + 20'(FWD_PGD_OFS_PS)
		: 20'(FLY_PGD_SLOPE_PS) * 20'(kohm) + 20'(FLY_PGD_OFS_PS);
	assign spacePs = forward ? 20'(FWD_SPACE_SLOPE_PS) * 20'(kohm) + 20'(FWD_SPACE_OFS_PS)
		: 20'(FLY_SPACE_PS);

	// Edges past the period simply never fire; short on-times are the user's job
	assign cnt9    = {1'b0, cycCnt_q};
	assign pgOnAt  = {1'b0, pgDelayCyc};
	assign pgOffAt = pgOnAt + {1'b0, onTime};
	assign sgOnAt  = pgOffAt + {1'b0, spacingCyc};
	assign fbEndAt = sgOnAt + 9'(FB_WINDOW_CYCLES);
	assign wrap    = cycCnt_q == 8'(SW_PERIOD_CYCLES - 1);
	assign pgOn    = run && cnt9 >= pgOnAt && cnt9 < pgOffAt;
	assign sgOn    = run && cnt9 >= sgOnAt;
	assign fbOn    = run && !forward && cnt9 >= sgOnAt && cnt9 < fbEndAt;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cycCnt_q       <= 8'h0;
			primaryGate    <= 1'b0;
			secondaryGate  <= 1'b0;
			feedbackEnable <= 1'b0;
			pgDelayCyc     <= 8'h1;
			spacingCyc     <= 8'h1;
		end
		else
		begin
			cycCnt_q       <= (wrap || !run) ? 8'h0 : cycCnt_q + 8'h1;
			primaryGate    <= pgOn;
			secondaryGate  <= sgOn;
			feedbackEnable <= fbOn;
			pgDelayCyc     <= pdpai_cyc(pgdPs);
			spacingCyc     <= pdpai_cyc(spacePs);
		end
	end

endmodule

// file: verilog/pdpai_core.sv
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module pdpai_core
	import pdpai_pkg::*;
#(
	parameter int unsigned START_CYC = START_DELAY_CYCLES
)
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        portAboveHsOn,
	input  wire logic        portAboveHsOff,
	input  wire logic        portAboveReset,
	input  wire logic        gateCharged,
	input  wire logic        auxAboveThresh,
	input  wire logic        classProbe,
	input  wire logic        classRangeUpper,
	input  wire logic        topologyForward,
	input  wire logic [5:0]  ffsdlyKohm,
	output logic             gatePullupEn,
	output logic             gatePullDown,
	output logic             signatureDisconnect,
	output logic             classDisable,
	output logic             auxHystSink,
	output logic             regulatorRun,
	output logic             powerAllocOut,
	output logic             powerAllocOen,
	output logic             primaryGate,
	output logic             secondaryGate,
	output logic             feedbackEnable
);

	// Indicator state from aux, class range and event count
	function automatic pdpai_ind_t pdpai_ind_sel(input logic aux, input logic upper,
		input logic [2:0] events);
		pdpai_ind_t s;
		if (aux)
			s = upper ? IND_D25 : IND_LOWZ;
		else if (events <= 3'h1)
			s = IND_HIZ;
		else if (!upper || events <= 3'h3)
			s = IND_LOWZ;
		else if (events == 3'h4)
			s = IND_D50;
		else
			s = IND_D25;
		return s;
	endfunction

	pdpai_hs_t   hs_q;
	pdpai_hs_t   hs_d;
	pdpai_ind_t  ind_q;
	pdpai_ind_t  ind_d;
	logic [12:0] startCnt_q;
	logic [12:0] startCnt_d;
	logic        startDone;
	logic [2:0]  events_q;
	logic [2:0]  events_d;
	logic        probe_q;
	logic        probeRise;
	logic [7:0]  indCnt_q;
	logic [7:0]  indCnt_d;
	logic        lowZ;
	logic        convEn_q;
	logic [7:0]  onTime_q;
	logic [11:0] awAddr_q;
	logic        awHeld_q;
	logic [31:0] wData_q;
	logic        wStrb0_q;
	logic        wHeld_q;
	logic        doWrite;
	logic        wrCtrl;
	logic        wrOnTime;
	logic        wrHit;
	logic        awHs;
	logic        wHs;
	logic        bHs;
	logic        arHs;
	logic        rHs;
	logic [11:0] rdAddr;
	logic        rdHit;
	logic [31:0] rdMux;
	logic [31:0] statusWord;
	logic [31:0] timingWord;
	logic [7:0]  pgDelayCyc;
	logic [7:0]  spacingCyc;
	logic        swRun;

	// Hot-swap and start-up sequencing
	assign startDone = startCnt_q == 13'(START_CYC - 1);

	always_comb
	begin
		hs_d = hs_q;
		unique case (hs_q)
			HS_OFF:
				if (portAboveHsOn)
					hs_d = HS_CHARGE;
			HS_CHARGE:
				if (gateCharged)
					hs_d = HS_DELAY;
			HS_DELAY:
				if (startDone)
					hs_d = HS_RUN;
			HS_RUN:
				hs_d = HS_RUN;
			HS_AUX:
				if (!auxAboveThresh)
					hs_d = HS_OFF;
			default:
				hs_d = HS_OFF;
		endcase
		// Aux override beats every supply state; a sagging port drops power
		if (auxAboveThresh)
			hs_d = HS_AUX;
		else if (hs_q != HS_OFF && hs_q != HS_AUX && !portAboveHsOff)
			hs_d = HS_OFF;
	end

	assign startCnt_d = (hs_q == HS_DELAY && !startDone) ? startCnt_q + 13'h1 : 13'h0;

	// Classification event counting
	assign probeRise = classProbe && !probe_q;

	always_comb
	begin
		events_d = events_q;
		if (!portAboveReset)
			events_d = 3'h0;
		else if (probeRise && !auxAboveThresh && events_q < MAX_EVENTS)
			events_d = events_q + 3'h1;
	end

	// Indicator output; duty counted against a fixed period
	assign ind_d    = pdpai_ind_sel(auxAboveThresh, classRangeUpper, events_q);
	assign indCnt_d = (indCnt_q == 8'(IND_PERIOD_CYCLES - 1)) ? 8'h0 : indCnt_q + 8'h1;
	assign lowZ     = (ind_q == IND_LOWZ)
		|| (ind_q == IND_D50 && indCnt_q < 8'(IND_PERIOD_CYCLES / 2))
		|| (ind_q == IND_D25 && indCnt_q < 8'(IND_PERIOD_CYCLES / 4));

	// Converter runs once started, or from aux power, when software allows
	assign swRun = convEn_q && (hs_q == HS_RUN || hs_q == HS_AUX);

	pdpai_switch u_switch
	(
		.ref_clk        (ref_clk),
		.rstn           (rstn),
		.run            (regulatorRun),
		.forward        (topologyForward),
		.kohm           (ffsdlyKohm),
		.onTime         (onTime_q),
		.primaryGate    (primaryGate),
		.secondaryGate  (secondaryGate),
		.feedbackEnable (feedbackEnable),
		.pgDelayCyc     (pgDelayCyc),
		.spacingCyc     (spacingCyc)
	);

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			hs_q       <= HS_OFF;
			startCnt_q <= 13'h0;
			events_q   <= 3'h0;
			probe_q    <= 1'b0;
			ind_q      <= IND_HIZ;
			indCnt_q   <= 8'h0;
		end
		else
		begin
			hs_q       <= hs_d;
			startCnt_q <= startCnt_d;
			events_q   <= events_d;
			probe_q    <= classProbe;
			ind_q      <= ind_d;
			indCnt_q   <= indCnt_d;
		end
	end

	// Pin drive, all registered
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gatePullupEn        <= 1'b0;
			gatePullDown        <= 1'b1;
			signatureDisconnect <= 1'b0;
			classDisable        <= 1'b0;
			auxHystSink         <= 1'b1;
			regulatorRun        <= 1'b0;
			powerAllocOut       <= 1'b1;
			powerAllocOen       <= 1'b1;
		end
		else
		begin
			gatePullupEn        <= hs_d == HS_CHARGE || hs_d == HS_DELAY
				|| hs_d == HS_RUN;
			gatePullDown        <= hs_d == HS_OFF || hs_d == HS_AUX;
			signatureDisconnect <= auxAboveThresh;
			classDisable        <= auxAboveThresh;
			auxHystSink         <= !auxAboveThresh;
			regulatorRun        <= swRun;
			powerAllocOut       <= 1'b1;
			powerAllocOen       <= !lowZ;
		end
	end

	// AXI4-Lite write path: address and data taken in either order
	assign awHs     = s_axi_awvalid && s_axi_awready;
	assign wHs      = s_axi_wvalid && s_axi_wready;
	assign bHs      = s_axi_bvalid && s_axi_bready;
	assign doWrite  = awHeld_q && wHeld_q && !s_axi_bvalid;
	assign wrCtrl   = doWrite && awAddr_q == REG_CTRL && wStrb0_q;
	assign wrOnTime = doWrite && awAddr_q == REG_ONTIME && wStrb0_q;
	assign wrHit    = awAddr_q == REG_CTRL || awAddr_q == REG_ONTIME;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			awHeld_q      <= 1'b0;
			wHeld_q       <= 1'b0;
			awAddr_q      <= 12'h0;
			wData_q       <= 32'h0;
			wStrb0_q      <= 1'b0;
			convEn_q      <= CTRL_RST;
			onTime_q      <= ONTIME_RST;
		end
		else
		begin
			if (awHs)
			begin
				awAddr_q      <= {s_axi_awaddr[11:2], 2'h0};
				awHeld_q      <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (wHs)
			begin
				wData_q      <= s_axi_wdata;
				wStrb0_q     <= s_axi_wstrb[0];
				wHeld_q      <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite)
			begin
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLV;
			end
			if (bHs)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (wrCtrl)
				convEn_q <= wData_q[0];
			if (wrOnTime)
				onTime_q <= wData_q[7:0];
		end
	end

	// AXI4-Lite read path
	assign arHs       = s_axi_arvalid && s_axi_arready;
	assign rHs        = s_axi_rvalid && s_axi_rready;
	assign rdAddr     = {s_axi_araddr[11:2], 2'h0};
	assign statusWord = {18'h0, auxAboveThresh, topologyForward, ind_q, events_q, hs_q};
	assign timingWord = {16'h0, spacingCyc, pgDelayCyc};
	assign rdHit      = rdAddr == REG_CTRL || rdAddr == REG_ONTIME
		|| rdAddr == REG_STATUS || rdAddr == REG_TIMING;
	assign rdMux      = (rdAddr == REG_CTRL)   ? {31'h0, convEn_q}
		: (rdAddr == REG_ONTIME) ? {24'h0, onTime_q}
		: (rdAddr == REG_STATUS) ? statusWord
		: (rdAddr == REG_TIMING) ? timingWord
		: 32'h0;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (arHs)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdMux;
			s_axi_rresp   <= rdHit ? RESP_OKAY : RESP_SLV;
		end
		else if (rHs)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// file: tb/pdpai_core_props.sv
`timescale 1ns/1ps
module pdpai_core_props
	import pdpai_pkg::*;
#(
	parameter int unsigned START_CYC = START_DELAY_CYCLES
)
(
	input logic ref_clk,
	input logic rstn,
	input logic portAboveHsOn,
	input logic portAboveHsOff,
	input logic gateCharged,
	input logic auxAboveThresh,
	input logic classRangeUpper,
	input logic topologyForward,
	input logic gatePullupEn,
	input logic gatePullDown,
	input logic signatureDisconnect,
	input logic classDisable,
	input logic auxHystSink,
	input logic regulatorRun,
	input logic powerAllocOut,
	input logic powerAllocOen,
	input logic primaryGate,
	input logic secondaryGate,
	input logic feedbackEnable
);
	// Counters stand in for long repetitions, which the tools would unroll
	logic [15:0] chgCnt_q;
	logic [7:0]  fbCnt_q;
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			chgCnt_q <= 16'h0;
			fbCnt_q  <= 8'h0;
		end
		else
		begin
			chgCnt_q <= gateCharged ? chgCnt_q + {15'h0, ~&chgCnt_q} : 16'h0;
			fbCnt_q  <= feedbackEnable ? fbCnt_q + 8'h1 : 8'h0;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_pullup_start: assert property (
		$rose(portAboveHsOn) && portAboveHsOff && !auxAboveThresh |-> ##[1:2] gatePullupEn)
		else $error("gate pull-up not started");
	a_start_delay: assert property (
		$rose(regulatorRun) && !auxAboveThresh |-> chgCnt_q >= 16'(START_CYC))
		else $error("regulator started before the start delay");
	a_aux_override: assert property (
		auxAboveThresh |=> signatureDisconnect && classDisable && gatePullDown && !gatePullupEn)
		else $error("aux override outputs wrong");
	a_aux_hyst: assert property (1'h1 |=> auxHystSink == !$past(auxAboveThresh))
		else $error("hysteresis sink wrong");
	// Aux with a lower class must end up driven to the supply, two stages late
	a_alloc_level: assert property (
		(auxAboveThresh && !classRangeUpper) [*3] |-> powerAllocOut && !powerAllocOen)
		else $error("aux lower indicator not low impedance");
	a_fb_forward: assert property (topologyForward [*3] |-> !feedbackEnable)
		else $error("feedback enabled in forward mode");
	a_fb_length: assert property (
		$fell(feedbackEnable) && regulatorRun |-> fbCnt_q == 8'(FB_WINDOW_CYCLES))
		else $error("feedback window length wrong");
	a_gate_overlap: assert property (1'h1 |-> !(primaryGate && secondaryGate))
		else $error("primary and secondary gates overlap");
	a_gates_idle: assert property (
		!regulatorRun [*3] |-> !primaryGate && !secondaryGate)
		else $error("gates switching while stopped");
endmodule

bind pdpai_core pdpai_core_props #(.START_CYC(START_CYC)) i_props
(
	.ref_clk, .rstn, .portAboveHsOn, .portAboveHsOff, .gateCharged, .auxAboveThresh,
	.classRangeUpper, .topologyForward, .gatePullupEn, .gatePullDown, .signatureDisconnect,
	.classDisable, .auxHystSink, .regulatorRun, .powerAllocOut, .powerAllocOen, .primaryGate,
	.secondaryGate, .feedbackEnable
);

// file: tb/pdpai_pse_model.sv
`timescale 1ns/1ps
module pdpai_pse_model
(
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       powerReq,
	input  wire logic [2:0] eventReq,
	output logic            portAboveReset,
	output logic            classProbe,
	output logic            portAboveHsOn,
	output logic            portAboveHsOff,
	output logic            pseDone
);
	// One 8-cycle slot per event, probe high in the second half of each
	logic [5:0] step_q;
	wire  [5:0] lastStep = {eventReq, 3'h0};
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			step_q <= 6'h0;
		else if (!powerReq)
			step_q <= 6'h0;
		else if (step_q <= lastStep)
			step_q <= step_q + 6'h1;
	end
	// Dropping the request drops the whole port supply at once
	assign portAboveReset = powerReq;
	assign classProbe     = powerReq && step_q < lastStep && step_q[2];
	assign pseDone        = powerReq && step_q > lastStep;
	assign portAboveHsOn  = pseDone;
	assign portAboveHsOff = pseDone;
endmodule

// file: tb/pdpai_core_bench.sv
`timescale 1ns/1ps
module pdpai_core_bench;
	import pdpai_pkg::*;
	localparam int unsigned START = 8;
	logic        ref_clk, rstn, powerReq, pseDone;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d, e;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        portAboveHsOn, portAboveHsOff, portAboveReset, gateCharged, auxAboveThresh;
	logic        classProbe, classRangeUpper, topologyForward;
	logic [5:0]  ffsdlyKohm;
	logic [2:0]  eventReq;
	logic        gatePullupEn, gatePullDown, signatureDisconnect, classDisable, auxHystSink;
	logic        regulatorRun, powerAllocOut, powerAllocOen, primaryGate, secondaryGate;
	logic        feedbackEnable;
	int          failures = 0, totalChecks = 0, cycles = 0, c;

	pdpai_core #(.START_CYC(START)) i_dut
	(
		.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .portAboveHsOn, .portAboveHsOff, .portAboveReset,
		.gateCharged, .auxAboveThresh, .classProbe, .classRangeUpper, .topologyForward,
		.ffsdlyKohm, .gatePullupEn, .gatePullDown, .signatureDisconnect, .classDisable,
		.auxHystSink, .regulatorRun, .powerAllocOut, .powerAllocOen, .primaryGate,
		.secondaryGate, .feedbackEnable
	);
	pdpai_pse_model i_pse
	(
		.ref_clk, .rstn, .powerReq, .eventReq, .portAboveReset, .classProbe,
		.portAboveHsOn, .portAboveHsOff, .pseDone
	);

	initial
	begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Crude pass gate: charges while pulled up, discharges when pulled down
	always @(posedge ref_clk)
	begin
		gateCharged <= !gatePullDown && (gateCharged || gatePullupEn);
		cycles++;
		if (cycles == 30000)
		begin
			failures++;
			giveVerdict();
		end
	end

	task automatic giveVerdict();
		$display("checks %0d failures %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic axiWrite(input logic [11:0] a, input logic [31:0] v);
		bit aw, w;
		aw = 1'h0;
		w = 1'h0;
		s_axi_awaddr <= {20'h0, a};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do
		begin
			@(posedge ref_clk);
			aw |= s_axi_awready;
			w |= s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		while (!(aw && w));
		s_axi_bready <= 1'h1;
		do @(posedge ref_clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic axiRead(input logic [11:0] a);
		s_axi_araddr <= {20'h0, a};
		s_axi_arvalid <= 1'h1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// Counting over a whole period makes the result independent of its phase
	task automatic count(input int sel, input int len);
		c = 0;
		repeat (len)
		begin
			@(posedge ref_clk);
			c += (sel == 2) ? (primaryGate === 1'h1)
				: (sel == 1) ? (feedbackEnable === 1'h1) : (powerAllocOen === 1'h0);
		end
	endtask
	function automatic int expLow(input bit aux, input bit up, input int n);
		if (aux)
			return up ? IND_PERIOD_CYCLES / 4 : IND_PERIOD_CYCLES;
		if (n <= 1)
			return 0;
		if (!up || n <= 3)
			return IND_PERIOD_CYCLES;
		return (n == 4) ? IND_PERIOD_CYCLES / 2 : IND_PERIOD_CYCLES / 4;
	endfunction
	function automatic logic [7:0] toCyc(input int unsigned ps);
		return 8'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	endfunction

	initial
	begin
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{auxAboveThresh, classRangeUpper, powerReq} = '0;
		s_axi_wstrb = 4'hF;
		topologyForward = 1'h1;
		ffsdlyKohm = 6'h14;
		eventReq = 3'h0;
		rstn = 1'h0;
		repeat (5) @(posedge ref_clk);
		rstn <= 1'h1;
		axiRead(REG_CTRL);
		check("ctrl reset", d, 32'(CTRL_RST));
		axiRead(REG_ONTIME);
		check("ontime reset", d, 32'(ONTIME_RST));
		axiRead(12'h010);
		check("unmapped read", {d[29:0], r}, {30'h0, RESP_SLV});
		axiWrite(REG_STATUS, 32'h0);
		check("status write", r, RESP_SLV);
		axiWrite(REG_ONTIME, 32'h30);
		axiRead(REG_ONTIME);
		check("ontime", d, 32'h30);
		for (int u = 0; u < 2; u++)
			for (int n = 1; n <= 5; n++)
			begin
				powerReq <= 1'h0;
				classRangeUpper <= u[0];
				eventReq <= 3'(n);
				// The supply drop needs an edge to clear the count before it is read
				repeat (2) @(posedge ref_clk);
				axiRead(REG_STATUS);
				check("count cleared", d[7:5], 3'h0);
				powerReq <= 1'h1;
				do @(posedge ref_clk); while (!regulatorRun);
				axiRead(REG_STATUS);
				check("event count", d[7:5], n);
				check("run state", d[4:0], HS_RUN);
				count(0, IND_PERIOD_CYCLES);
				check("indicator low time", c, expLow(0, u, n));
			end
		auxAboveThresh <= 1'h1;
		repeat (4) @(posedge ref_clk);
		e = {27'h0, signatureDisconnect, classDisable, gatePullDown, auxHystSink, gatePullupEn};
		check("aux pins", e, 32'h1C);
		count(0, IND_PERIOD_CYCLES);
		check("aux upper", c, expLow(1, 1, 0));
		classRangeUpper <= 1'h0;
		repeat (4) @(posedge ref_clk);
		count(0, IND_PERIOD_CYCLES);
		check("aux lower", c, expLow(1, 0, 0));
		auxAboveThresh <= 1'h0;
		repeat (4) @(posedge ref_clk);
		check("hysteresis sink", auxHystSink, 1'h1);
		do @(posedge ref_clk); while (!regulatorRun);
		for (int t = 1; t >= 0; t--)
		begin
			axiWrite(REG_CTRL, 32'h0);
			repeat (3) @(posedge ref_clk);
			check("run off", regulatorRun, 1'h0);
			topologyForward <= t[0];
			ffsdlyKohm <= t ? 6'h14 : 6'h0A;
			axiWrite(REG_CTRL, 32'h1);
			e = {16'h0, toCyc(t ? FWD_SPACE_SLOPE_PS * 20 + FWD_SPACE_OFS_PS : FLY_SPACE_PS),
				toCyc(t ? FWD_PGD_SLOPE_PS * 20 + FWD_PGD_OFS_PS : FLY_PGD_SLOPE_PS * 10
				+ FLY_PGD_OFS_PS)};
			axiRead(REG_TIMING);
			check("timing", d, e);
			do @(posedge ref_clk); while (!regulatorRun);
			repeat (SW_PERIOD_CYCLES) @(posedge ref_clk);
			count(1, SW_PERIOD_CYCLES);
			check("feedback window", c, t ? 0 : FB_WINDOW_CYCLES);
			count(2, SW_PERIOD_CYCLES);
			check("primary on time", c, 32'h30);
		end
		giveVerdict();
	end
endmodule
